/* pbrt_pkg.sv */
// Package for the push-button reset timer: timing constants, variants, states and carriers
package pbrt_pkg;
    // Clock rate in Hz (10 ns period)
    localparam longint CLK_HZ = 100_000_000;
    // Hold times in milliseconds as printed
    localparam longint HOLD_LONG_MS = 12_500; // Level variant, strap high
    localparam longint HOLD_STD_MS = 7_500; // Strap low, any variant
    localparam longint HOLD_ZERO_MS = 0; // Fixed-pulse variant, strap high
    // Fixed reset pulse in milliseconds
    localparam longint PULSE_MS = 400;
    // Detection delay and start-up delay in microseconds
    localparam longint DETECT_US = 150;
    localparam longint STARTUP_US = 300;
    // Cycle counts derived from the rate
    localparam longint HOLD_LONG_CYC = HOLD_LONG_MS * (CLK_HZ / 1000);
    localparam longint HOLD_STD_CYC = HOLD_STD_MS * (CLK_HZ / 1000);
    localparam longint HOLD_ZERO_CYC = HOLD_ZERO_MS * (CLK_HZ / 1000);
    localparam longint PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
    localparam longint DETECT_CYC = DETECT_US * (CLK_HZ / 1_000_000);
    localparam longint STARTUP_CYC = STARTUP_US * (CLK_HZ / 1_000_000);
    // Timer width, wide enough for the longest hold
    localparam int CNT_W = 32;
    // Reset values
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic STRAP_RST = 1'b0;
    // Product variants
    typedef enum logic [1:0] {
        PBRT_LEVEL_DUAL = 2'h0, // Released by a button
        PBRT_PULSE_DUAL = 2'h1, // Fixed pulse, two buttons
        PBRT_PULSE_SINGLE = 2'h2 // Fixed pulse, one button
    } pbrt_variant_t;
    // Controller states, Gray along idle-hold-reset-rearm
    typedef enum logic [1:0] {
        PBRT_ST_IDLE = 2'b00, // Waiting for a press
        PBRT_ST_HOLD = 2'b01, // Timing a press
        PBRT_ST_RESET = 2'b11, // Reset driven low
        PBRT_ST_REARM = 2'b10 // Waiting for a release
    } pbrt_state_t;
    // Open-drain output carrier
    typedef struct packed {
        logic out; // Level driven when enabled, always low
        logic oe; // High while pulling the net low
    } pbrt_od_t;
endpackage

/* pbrt_timer.sv */
// Push-button long-press reset generator with open-drain reset output
`timescale 1ns/1ns
// Contract
// - Dual variants need both buttons low throughout hold.
// - Level variant releases when either button rises.
// - One reset per valid hold condition.
// - Rearm needs a release then a full hold.
// - Fixed pulse lasts 400 ms regardless of buttons.
// - Single variant watches only button A.
// - Strap selects hold time per variant.
// - Strap sampled at power-up and while released.
// - Output driven low only in reset, else released.
// - Glitches during fixed pulse are ignored.
// - Release during pulse is acted on after it.
// - Zero hold asserts after 150 us detection delay.
// - Pressed at power-up asserts after 300 us at the earliest.
module pbrt_timer #(
    parameter pbrt_pkg::pbrt_variant_t VARIANT = pbrt_pkg::PBRT_PULSE_DUAL, // Product variant
    parameter logic [pbrt_pkg::CNT_W-1:0] HOLD_LONG = pbrt_pkg::CNT_W'(pbrt_pkg::HOLD_LONG_CYC), // 12.5 s
    parameter logic [pbrt_pkg::CNT_W-1:0] HOLD_STD = pbrt_pkg::CNT_W'(pbrt_pkg::HOLD_STD_CYC), // 7.5 s
    parameter logic [pbrt_pkg::CNT_W-1:0] PULSE_LEN = pbrt_pkg::CNT_W'(pbrt_pkg::PULSE_CYC), // 400 ms
    parameter logic [pbrt_pkg::CNT_W-1:0] DETECT_LEN = pbrt_pkg::CNT_W'(pbrt_pkg::DETECT_CYC), // 150 us
    parameter logic [pbrt_pkg::CNT_W-1:0] STARTUP_LEN = pbrt_pkg::CNT_W'(pbrt_pkg::STARTUP_CYC) // 300 us
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic button_in_a_n,
    input wire logic button_in_b_n,
    input wire logic delay_select_strap,
    output pbrt_pkg::pbrt_od_t rst_od
);
    // Synchroniser stages for the three pins
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    // Synchronised levels
    logic a_low;
    logic b_low;
    logic strap_s;
    // Buttons taken as pressed for this variant
    logic pressed;
    // Sampled strap
    logic strap_r;
    // Start-up timer and its done flag
    logic [pbrt_pkg::CNT_W-1:0] boot_cnt_r;
    logic boot_done_r;
    // Main timer and state
    logic [pbrt_pkg::CNT_W-1:0] cnt_r;
    pbrt_pkg::pbrt_state_t state_r;
    pbrt_pkg::pbrt_state_t state_nxt;
    // Selected hold length and the length that applies to this press
    logic [pbrt_pkg::CNT_W-1:0] hold_len;
    logic [pbrt_pkg::CNT_W-1:0] target;
    logic fixed_pulse;
    // Run of consecutive pressed cycles, read only by the checks
    logic [pbrt_pkg::CNT_W-1:0] press_run_r;

    // Hold length from variant and strap
    function automatic logic [pbrt_pkg::CNT_W-1:0] hold_sel(input logic strap);
        if (VARIANT == pbrt_pkg::PBRT_LEVEL_DUAL) begin
            hold_sel = strap ? HOLD_LONG : HOLD_STD;
        end else begin
            hold_sel = strap ? pbrt_pkg::CNT_W'(pbrt_pkg::HOLD_ZERO_CYC) : HOLD_STD;
        end
    endfunction

    // Two-flop synchronisers for pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end else begin
            sync1_r <= {delay_select_strap, button_in_b_n, button_in_a_n};
            sync2_r <= sync1_r;
        end
    end

    assign a_low = ~sync2_r[0];
    assign b_low = ~sync2_r[1];
    assign strap_s = sync2_r[2];
    assign fixed_pulse = (VARIANT != pbrt_pkg::PBRT_LEVEL_DUAL);

    // Press condition per variant
    always_comb begin
        if (VARIANT == pbrt_pkg::PBRT_PULSE_SINGLE) begin
            pressed = a_low;
        end else begin
            pressed = a_low & b_low;
        end
    end

    // Strap sampling: through the start-up window, then only while released
    // Window outlasts the synchroniser, so the pin and not its reset value is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_r <= pbrt_pkg::STRAP_RST;
        end else if (!boot_done_r || !pressed) begin
            strap_r <= strap_s;
        end
    end

    // Start-up window counter after reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_cnt_r <= pbrt_pkg::CNT_RST;
            boot_done_r <= 1'b0;
        end else if (!boot_done_r) begin
            if (boot_cnt_r >= STARTUP_LEN - 1) begin
                boot_done_r <= 1'b1;
            end
            boot_cnt_r <= boot_cnt_r + 1'b1;
        end
    end

    assign hold_len = hold_sel(strap_r);
    // Zero hold becomes detection delay; boot press waits at least start-up time
    always_comb begin
        target = (hold_len == pbrt_pkg::CNT_RST) ? DETECT_LEN : hold_len;
        if (!boot_done_r && target < STARTUP_LEN) begin
            target = STARTUP_LEN;
        end
    end

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pbrt_pkg::PBRT_ST_IDLE: begin
                if (pressed) begin
                    state_nxt = pbrt_pkg::PBRT_ST_HOLD;
                end
            end
            pbrt_pkg::PBRT_ST_HOLD: begin
                if (!pressed) begin
                    state_nxt = pbrt_pkg::PBRT_ST_IDLE;
                end else if (cnt_r >= target - 1) begin
                    state_nxt = pbrt_pkg::PBRT_ST_RESET;
                end
            end
            pbrt_pkg::PBRT_ST_RESET: begin
                if (fixed_pulse) begin
                    if (cnt_r >= PULSE_LEN - 1) begin
                        state_nxt = pbrt_pkg::PBRT_ST_REARM;
                    end
                end else if (!pressed) begin
                    state_nxt = pbrt_pkg::PBRT_ST_IDLE;
                end
            end
            pbrt_pkg::PBRT_ST_REARM: begin
                if (!pressed) begin
                    state_nxt = pbrt_pkg::PBRT_ST_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= pbrt_pkg::PBRT_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Shared timer: counts hold or pulse, clears on state change
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= pbrt_pkg::CNT_RST;
        end else if (state_nxt != state_r) begin
            cnt_r <= pbrt_pkg::CNT_RST;
        end else if (state_r == pbrt_pkg::PBRT_ST_HOLD || state_r == pbrt_pkg::PBRT_ST_RESET) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Open-drain output, pulls low only in reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_od <= '{out: 1'b0, oe: 1'b0};
        end else begin
            rst_od <= '{out: 1'b0, oe: (state_nxt == pbrt_pkg::PBRT_ST_RESET)};
        end
    end

    // Consecutive pressed cycles, saturating
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            press_run_r <= pbrt_pkg::CNT_RST;
        end else if (!pressed) begin
            press_run_r <= pbrt_pkg::CNT_RST;
        end else if (press_run_r != {pbrt_pkg::CNT_W{1'b1}}) begin
            press_run_r <= press_run_r + 1'b1;
        end
    end

    // Assertion helpers
    sequence released_s;
        !pressed;
    endsequence
    sequence enter_reset_s;
        state_r != pbrt_pkg::PBRT_ST_RESET ##1 state_r == pbrt_pkg::PBRT_ST_RESET;
    endsequence
    sequence enter_hold_s;
        state_r != pbrt_pkg::PBRT_ST_HOLD ##1 state_r == pbrt_pkg::PBRT_ST_HOLD;
    endsequence
    sequence pulse_last_s;
        fixed_pulse && state_r == pbrt_pkg::PBRT_ST_RESET && cnt_r == PULSE_LEN - 1;
    endsequence

    // Reset entered only from a held press
    hold_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
        enter_reset_s |-> $past(state_r) == pbrt_pkg::PBRT_ST_HOLD && $past(pressed))
        else $error("reset entered without held press");
    // Level variant releases on button rise
    level_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!fixed_pulse && state_r == pbrt_pkg::PBRT_ST_RESET) ##0 released_s
        |=> state_r == pbrt_pkg::PBRT_ST_IDLE)
        else $error("level reset not released");
    // No second reset without a release
    single_shot_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == pbrt_pkg::PBRT_ST_REARM && pressed |=> state_r == pbrt_pkg::PBRT_ST_REARM)
        else $error("rearmed while still pressed");
    // Rearm leads only to idle
    rearm_path_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == pbrt_pkg::PBRT_ST_REARM |=> state_r inside {pbrt_pkg::PBRT_ST_REARM, pbrt_pkg::PBRT_ST_IDLE})
        else $error("rearm left wrongly");
    // Fixed pulse ends at exact length
    pulse_len_a: assert property (@(posedge clk) disable iff (!arst_n)
        fixed_pulse && state_r == pbrt_pkg::PBRT_ST_RESET && cnt_r == PULSE_LEN - 1
        |=> state_r == pbrt_pkg::PBRT_ST_REARM)
        else $error("pulse length wrong");
    // Glitches do not cut the fixed pulse
    pulse_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        fixed_pulse && state_r == pbrt_pkg::PBRT_ST_RESET && cnt_r < PULSE_LEN - 1
        |=> state_r == pbrt_pkg::PBRT_ST_RESET)
        else $error("pulse cut short");
    // Output enable follows reset state
    od_match_a: assert property (@(posedge clk) disable iff (!arst_n)
        rst_od.oe == (state_r == pbrt_pkg::PBRT_ST_RESET) && !rst_od.out)
        else $error("open drain mismatch");
    // Strap held during a press
    strap_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        pressed && $past(pressed) && $past(boot_done_r) |-> $stable(strap_r))
        else $error("strap resampled during press");
    // Button rise restarts the hold
    hold_restart_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == pbrt_pkg::PBRT_ST_HOLD && !pressed |=> cnt_r == pbrt_pkg::CNT_RST)
        else $error("hold not restarted");

    // Full hold seen before reset starts
    hold_time_a: assert property (@(posedge clk) disable iff (!arst_n)
        enter_reset_s |-> $past(press_run_r) >= $past(target))
        else $error("reset before full hold");

    // Dual variants stay idle on one button
    dual_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        VARIANT != pbrt_pkg::PBRT_PULSE_SINGLE && state_r == pbrt_pkg::PBRT_ST_IDLE && !(a_low && b_low)
        |=> state_r == pbrt_pkg::PBRT_ST_IDLE)
        else $error("hold started on one button");

    // Single variant starts on button A alone
    single_start_a: assert property (@(posedge clk) disable iff (!arst_n)
        VARIANT == pbrt_pkg::PBRT_PULSE_SINGLE && state_r == pbrt_pkg::PBRT_ST_IDLE && a_low
        |=> state_r == pbrt_pkg::PBRT_ST_HOLD)
        else $error("single press not timed");

    // Level variant keeps reset while pressed
    level_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !fixed_pulse && state_r == pbrt_pkg::PBRT_ST_RESET && pressed
        |=> state_r == pbrt_pkg::PBRT_ST_RESET)
        else $error("level reset dropped while pressed");

    // Every hold timing starts from zero
    hold_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        enter_hold_s |-> cnt_r == pbrt_pkg::CNT_RST)
        else $error("hold began mid-count");

    // Pulse timing starts from zero
    pulse_start_a: assert property (@(posedge clk) disable iff (!arst_n)
        enter_reset_s |-> cnt_r == pbrt_pkg::CNT_RST)
        else $error("pulse began mid-count");

    // Release during the pulse is acted on after it
    rearm_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        pulse_last_s ##0 released_s ##1 released_s |=> state_r == pbrt_pkg::PBRT_ST_IDLE)
        else $error("release in pulse lost");

    // Strap low picks the standard hold
    target_std_a: assert property (@(posedge clk) disable iff (!arst_n)
        boot_done_r && !strap_r |-> target == HOLD_STD)
        else $error("standard hold not selected");

    // Level variant picks the long hold when high
    target_long_a: assert property (@(posedge clk) disable iff (!arst_n)
        boot_done_r && strap_r && !fixed_pulse |-> target == HOLD_LONG)
        else $error("long hold not selected");

    // Zero hold falls back to the detection delay
    target_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        boot_done_r && strap_r && fixed_pulse |-> target == DETECT_LEN)
        else $error("detection delay not used");

    // Start-up window holds off an early reset
    target_boot_a: assert property (@(posedge clk) disable iff (!arst_n)
        !boot_done_r |-> target >= STARTUP_LEN)
        else $error("start-up delay skipped");

    // Strap follows the pin while released
    strap_track_a: assert property (@(posedge clk) disable iff (!arst_n)
        boot_done_r && !pressed |=> strap_r == $past(strap_s))
        else $error("strap not resampled");
endmodule // pbrt_timer

/* pbrt_button_model.sv */
// Behavioural model of the two push-buttons and the pulled-up reset nets
`timescale 1ns/1ns
module pbrt_button_model (
    input wire logic press_a, // User holds button A
    input wire logic press_b, // User holds button B
    input wire logic oe_pulse, // Pulse device sinks its net
    input wire logic oe_level, // Level device sinks its net
    output logic button_a_n, // Pin A, pulled up when open
    output logic button_b_n, // Pin B, pulled up when open
    output logic net_pulse, // Reset net of the pulse device
    output logic net_level // Reset net of the level device
);
    // Open switches leave the pins to their pull-ups
    assign button_a_n = press_a ? 1'b0 : 1'b1;
    assign button_b_n = press_b ? 1'b0 : 1'b1;
    // Nets sit high unless a device sinks them
    assign net_pulse = oe_pulse ? 1'b0 : 1'b1;
    assign net_level = oe_level ? 1'b0 : 1'b1;
endmodule // pbrt_button_model

/* testbench.sv */
// Self-checking testbench for the push-button reset timer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench;
    localparam int HS = 15; // Short hold
    localparam int HL = 20; // Long hold
    localparam int PL = 8; // Pulse length
    localparam int DL = 3; // Detection delay
    localparam int SL = 5; // Start-up delay
    logic clk = 1'b0; // System clock
    logic arst_n = 1'b0; // Async reset
    logic press_a = 1'b0; // User holds A
    logic press_b = 1'b0; // User holds B
    logic strap = 1'b0; // Hold select strap
    logic btn_a_n, btn_b_n, net_p, net_l; // Pins and nets
    pbrt_pkg::pbrt_od_t od_p, od_l, od_s; // Open-drain outputs
    int fails = 0; // Mismatch count
    int n_tests = 0; // Comparison count
    int n, m; // Cycle counts
    // Clock generator
    initial begin
        forever #5 clk = ~clk;
    end
    // Fixed-pulse device under test
    pbrt_timer #(.VARIANT(pbrt_pkg::PBRT_PULSE_DUAL), .HOLD_LONG(32'(HL)), .HOLD_STD(32'(HS)), .PULSE_LEN(32'(PL)),
        .DETECT_LEN(32'(DL)), .STARTUP_LEN(32'(SL))) u_pbrt_timer (.clk(clk), .arst_n(arst_n),
        .button_in_a_n(btn_a_n), .button_in_b_n(btn_b_n), .delay_select_strap(strap), .rst_od(od_p));
    // Level device on the same buttons
    pbrt_timer #(.VARIANT(pbrt_pkg::PBRT_LEVEL_DUAL), .HOLD_LONG(32'(HL)), .HOLD_STD(32'(HS)), .PULSE_LEN(32'(PL)),
        .DETECT_LEN(32'(DL)), .STARTUP_LEN(32'(SL))) u_pbrt_timer_lvl (.clk(clk), .arst_n(arst_n),
        .button_in_a_n(btn_a_n), .button_in_b_n(btn_b_n), .delay_select_strap(strap), .rst_od(od_l));
    // Single-button pulse device, watches A only
    pbrt_timer #(.VARIANT(pbrt_pkg::PBRT_PULSE_SINGLE), .HOLD_LONG(32'(HL)), .HOLD_STD(32'(HS)), .PULSE_LEN(32'(PL)),
        .DETECT_LEN(32'(DL)), .STARTUP_LEN(32'(SL))) u_pbrt_timer_sgl (.clk(clk), .arst_n(arst_n),
        .button_in_a_n(btn_a_n), .button_in_b_n(btn_b_n), .delay_select_strap(strap), .rst_od(od_s));
    // Buttons and pulled-up nets
    pbrt_button_model u_pbrt_button_model (.press_a(press_a), .press_b(press_b), .oe_pulse(od_p.oe),
        .oe_level(od_l.oe), .button_a_n(btn_a_n), .button_b_n(btn_b_n), .net_pulse(net_p), .net_level(net_l));
    // Let c falling edges pass
    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask
    // Count cycles until a net reaches lvl, bounded
    task automatic wait_net(input bit sel_l, input logic lvl, output int c);
        c = 0;
        while (((sel_l ? net_l : net_p) !== lvl) && c < 100) begin
            @(negedge clk);
            c++;
        end
    endtask
    // Set both switches
    task automatic press(input logic a, input logic b);
        press_a = a;
        press_b = b;
    endtask
    // Verdict and end of run
    task automatic final_report;
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Glitch inside the pulse, then buttons kept low
    task automatic t_pulse;
        press(1'b1, 1'b1);
        wait_net(1'b0, 1'b0, n);
        `CHK("hold_std", 1'b1, n >= HS && n <= HS + 5);
        tick(2);
        press(1'b1, 1'b0);
        tick(2);
        press(1'b1, 1'b1);
        wait_net(1'b0, 1'b1, n);
        `CHK("pulse_glitch", PL, n + 4);
        tick(40);
        `CHK("one_shot", 1'b1, net_p);
        press(1'b0, 1'b0);
        tick(5);
    endtask
    // Release during the pulse, rearm after it
    task automatic t_release;
        press(1'b1, 1'b1);
        wait_net(1'b0, 1'b0, n);
        tick(2);
        press(1'b1, 1'b0);
        wait_net(1'b0, 1'b1, n);
        `CHK("pulse_rel", PL, n + 2);
        tick(3);
        press(1'b1, 1'b1);
        wait_net(1'b0, 1'b0, n);
        `CHK("rearm", 1'b1, n >= HS && n <= HS + 5);
        wait_net(1'b0, 1'b1, n);
        press(1'b0, 1'b0);
        tick(5);
    endtask
    // One button only, then an interrupted hold
    task automatic t_partial;
        press(1'b1, 1'b0);
        tick(20);
        `CHK("single_a", 1'b1, od_s.oe);
        tick(20);
        `CHK("a_only", 1'b1, net_p);
        press(1'b1, 1'b1);
        tick(10);
        press(1'b0, 1'b1);
        tick(3);
        press(1'b1, 1'b1);
        wait_net(1'b0, 1'b0, n);
        `CHK("restart", 1'b1, n >= HS && n <= HS + 5);
        wait_net(1'b0, 1'b1, n);
        press(1'b0, 1'b0);
        tick(5);
    endtask
    // Strap high: zero hold on pulse device, long hold on level device
    task automatic t_level;
        strap = 1'b1;
        tick(5);
        press(1'b1, 1'b1);
        wait_net(1'b0, 1'b0, n);
        `CHK("zero_hold", 1'b1, n >= DL && n <= DL + 5);
        wait_net(1'b1, 1'b0, m);
        `CHK("hold_long", 1'b1, n + m >= HL && n + m <= HL + 5);
        tick(10);
        `CHK("level_holds", 1'b0, net_l);
        press(1'b0, 1'b1);
        wait_net(1'b1, 1'b1, n);
        `CHK("level_rel", 1'b1, n <= 4);
        press(1'b0, 1'b0);
        tick(5);
    endtask
    // Buttons already low when reset ends
    task automatic t_startup;
        press(1'b1, 1'b1);
        arst_n = 1'b0;
        tick(2);
        `CHK("rst_idle", 1'b1, net_p);
        arst_n = 1'b1;
        wait_net(1'b0, 1'b0, n);
        `CHK("startup", 1'b1, n >= SL && n <= SL + 5);
        wait_net(1'b0, 1'b1, n);
        press(1'b0, 1'b0);
        tick(5);
        arst_n = 1'b0;
        strap = 1'b0;
        press(1'b1, 1'b1);
        tick(2);
        arst_n = 1'b1;
        wait_net(1'b0, 1'b0, n);
        `CHK("boot_strap", 1'b1, n >= HS && n <= HS + 5);
        wait_net(1'b0, 1'b1, n);
        press(1'b0, 1'b0);
        tick(5);
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #100000;
        fails++;
        final_report();
    end
    // Main sequence
    initial begin
        tick(3);
        arst_n = 1'b1;
        tick(2);
        `CHK("idle_net", 1'b1, net_p);
        `CHK("od_level", 1'b0, od_p.out);
        `CHK("od_level_l", 1'b0, od_l.out);
        t_pulse();
        t_release();
        t_partial();
        t_level();
        t_startup();
        final_report();
    end
endmodule // testbench
